// file: logic/emp_clk_div.sv
// Programmable divider for the divided output clock
`timescale 1ns/1ps
module emp_clk_div
	import emp_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       reset_n,
	input  wire logic       port_level,
	input  wire logic       port_tick,
	input  wire logic [1:0] factor,
	output logic            div_clk
);
	logic half_cnt;
	logic div_state;

	////////////////////////////////////////////////////////////////////////
	// Toggle state on port clock rising edges, on every second one when factor is DIV_BY4
	always_ff @(posedge clk)
	begin
		if (!reset_n)
		begin
			half_cnt  <= 1'b0;
			div_state <= 1'b0;
		end
		else if (port_tick)
		begin
			if (factor == DIV_BY4)
			begin
				half_cnt <= ~half_cnt;
				if (half_cnt)
					div_state <= ~div_state;
			end
			else
			begin
				half_cnt  <= 1'b0;
				div_state <= ~div_state;
			end
		end
	end

	always_ff @(posedge clk)
	begin
		if (!reset_n)
			div_clk <= 1'b0;
		else if (factor == DIV_BY1)
			div_clk <= port_level;
		else
			div_clk <= div_state;
	end

endmodule : emp_clk_div

// file: logic/emp_pins.sv
// External memory port clock selection and shared control pins
//
// Decided for this implementation: the strobed register port and the register addresses.
`timescale 1ns/1ps
module emp_pins
	import emp_pkg::*;
(
	input  wire logic                         clk,
	input  wire logic                         reset_n,
	input  wire logic [emp_pkg::REG_ADDR_W-1:0] reg_addr,
	input  wire logic [emp_pkg::REG_DATA_W-1:0] reg_wdata,
	input  wire logic                         reg_wr,
	input  wire logic                         reg_rd,
	output logic [emp_pkg::REG_DATA_W-1:0]    reg_rdata,
	input  wire logic                         port_in_clock_pin,
	input  wire logic [1:0]                   port_clock_strap_select,
	input  wire emp_pkg::emp_acc_req_t        acc_req,
	output logic                              acc_busy,
	output logic                              acc_done,
	input  wire logic                         async_ready_in,
	output logic                              full_rate_out_clock,
	output logic                              divided_out_clock,
	output logic [emp_pkg::EXT_ADDR_W-1:0]    ext_addr_bus,
	output logic [emp_pkg::SPACES-1:0]        space_select_n,
	output emp_pkg::emp_strobes_t             strobes,
	output logic                              sdram_clock_gate
);
	import emp_pkg::*;

	typedef enum logic [2:0] {ST_IDLE, ST_SETUP, ST_ROW, ST_STROBE, ST_HOLD} emp_state_t;

	logic [1:0]                strap;
	logic [1:0]                cnt4;
	logic [1:0]                cnt6;
	logic                      cpu4_clk;
	logic                      cpu6_clk;
	logic                      sel_level;
	logic                      port_level;
	logic                      port_level_d;
	logic                      port_tick;
	logic [1:0]                div_factor;
	logic                      gpo;
	logic                      self_refresh;
	logic [2:0]                space_cfg [SPACES];
	logic [SPACES-1:0]         space_is_sdram;
	emp_state_t                state;
	emp_state_t                next_state;
	emp_acc_req_t              cur;
	emp_mem_type_t             cur_type;
	logic                      cur_rsel;
	emp_strobes_t              next_strobes;

	////////////////////////////////////////////////////////////////////////
	// Clock strap capture while reset is held
	always_ff @(posedge clk)
	begin
		if (!reset_n)
			strap <= port_clock_strap_select;
	end

	// CPU/4 and CPU/6 clocks from the core clock
	always_ff @(posedge clk)
	begin
		if (!reset_n)
		begin
			cnt4     <= 2'h0;
			cpu4_clk <= 1'b0;
		end
		else if (cnt4 == CPU4_HALF - 2'h1)
		begin
			cnt4     <= 2'h0;
			cpu4_clk <= ~cpu4_clk;
		end
		else
			cnt4 <= cnt4 + 2'h1;
	end

	always_ff @(posedge clk)
	begin
		if (!reset_n)
		begin
			cnt6     <= 2'h0;
			cpu6_clk <= 1'b0;
		end
		else if (cnt6 == CPU6_HALF - 2'h1)
		begin
			cnt6     <= 2'h0;
			cpu6_clk <= ~cpu6_clk;
		end
		else
			cnt6 <= cnt6 + 2'h1;
	end

	always_comb
	begin
		case (strap)
			STRAP_CPU4: sel_level = cpu4_clk;
			STRAP_CPU6: sel_level = cpu6_clk;
			default:    sel_level = port_in_clock_pin;
		endcase
	end

	always_ff @(posedge clk)
	begin
		if (!reset_n)
		begin
			port_level   <= 1'b0;
			port_level_d <= 1'b0;
		end
		else
		begin
			port_level   <= sel_level;
			port_level_d <= port_level;
		end
	end

	assign port_tick = port_level & ~port_level_d;

	always_ff @(posedge clk)
	begin
		if (!reset_n)
			full_rate_out_clock <= 1'b0;
		else
			full_rate_out_clock <= port_level;
	end

	emp_clk_div u_div (
		.clk        (clk),
		.reset_n    (reset_n),
		.port_level (port_level),
		.port_tick  (port_tick),
		.factor     (div_factor),
		.div_clk    (divided_out_clock)
	);

	////////////////////////////////////////////////////////////////////////
	// Control register
	always_ff @(posedge clk)
	begin
		if (!reset_n)
		begin
			div_factor   <= DIV_BY1;
			gpo          <= 1'b1;
			self_refresh <= 1'b0;
		end
		else if (reg_wr && reg_addr == REG_CTRL)
		begin
			div_factor   <= reg_wdata[CTRL_DIV_LSB +: 2];
			gpo          <= reg_wdata[CTRL_GPO_BIT];
			self_refresh <= reg_wdata[CTRL_SREF_BIT];
		end
	end

	// Per-space secondary control registers
	generate
		for (genvar s = 0; s < SPACES; s++)
		begin : g_space
			localparam logic [7:0] OFS = REG_SPACE0 + 8'(s) * REG_SPACE_STEP;
			always_ff @(posedge clk)
			begin
				if (!reset_n)
					space_cfg[s] <= SEC_RESET;
				else if (reg_wr && reg_addr == OFS)
					space_cfg[s] <= reg_wdata[2:0];
			end
			assign space_is_sdram[s] = space_cfg[s][SEC_TYPE_LSB +: 2] == MEM_SDRAM;
			assign space_select_n[s] = !(state != ST_IDLE && cur.space == 2'(s));
		end
	endgenerate

	// Read data, one cycle after the strobe
	always_ff @(posedge clk)
	begin
		if (!reset_n)
			reg_rdata <= '0;
		else if (!reg_rd)
			reg_rdata <= '0;
		else if (reg_addr == REG_CTRL)
			reg_rdata <= {26'h0, self_refresh, gpo, 2'h0, div_factor};
		else if (reg_addr == REG_STATUS)
			reg_rdata <= {26'h0, async_ready_in, acc_busy, 2'h0, strap};
		else if (reg_addr >= REG_SPACE0 && reg_addr < REG_SPACE0 + 8'(SPACES) * REG_SPACE_STEP
			&& reg_addr[1:0] == 2'h0)
			reg_rdata <= {29'h0, space_cfg[reg_addr[3:2]]};
		else
			reg_rdata <= '0;
	end

	////////////////////////////////////////////////////////////////////////
	// Clock gate pin: self-refresh with SDRAM, else general output
	always_ff @(posedge clk)
	begin
		if (!reset_n)
			sdram_clock_gate <= 1'b1;
		else if (|space_is_sdram)
			sdram_clock_gate <= ~self_refresh;
		else
			sdram_clock_gate <= gpo;
	end

	////////////////////////////////////////////////////////////////////////
	// Access sequencer, paced by the port clock
	assign cur_type = emp_mem_type_t'(space_cfg[cur.space][SEC_TYPE_LSB +: 2]);
	assign cur_rsel = space_cfg[cur.space][SEC_RSEL_BIT];
	assign acc_busy = state != ST_IDLE;

	always_comb
	begin
		next_state = state;
		case (state)
			ST_IDLE:
				if (acc_req.start)
					next_state = ST_SETUP;
			ST_SETUP:
				if (port_tick)
					next_state = (cur_type == MEM_SDRAM) ? ST_ROW :
						(cur_type == MEM_NONE) ? ST_HOLD : ST_STROBE;
			ST_ROW:
				if (port_tick)
					next_state = ST_STROBE;
			ST_STROBE:
				if (port_tick && (cur_type != MEM_ASYNC || async_ready_in))
					next_state = ST_HOLD;
			ST_HOLD:
				if (port_tick)
					next_state = ST_IDLE;
			default:
				next_state = ST_IDLE;
		endcase
	end

	always_ff @(posedge clk)
	begin
		if (!reset_n)
			state <= ST_IDLE;
		else
			state <= next_state;
	end

	always_ff @(posedge clk)
	begin
		if (!reset_n)
			cur <= '0;
		else if (state == ST_IDLE && acc_req.start)
			cur <= acc_req;
	end

	always_ff @(posedge clk)
	begin
		if (!reset_n)
			acc_done <= 1'b0;
		else
			acc_done <= state == ST_HOLD && port_tick;
	end

	always_ff @(posedge clk)
	begin
		if (!reset_n)
			ext_addr_bus <= '0;
		else if (state == ST_IDLE && acc_req.start)
			ext_addr_bus <= acc_req.byte_addr[DW_SHIFT +: EXT_ADDR_W];
	end

	////////////////////////////////////////////////////////////////////////
	// Shared strobe decode by memory type (pins active low)
	always_comb
	begin
		next_strobes = '1;
		if (next_state == ST_ROW && cur_type == MEM_SDRAM)
			next_strobes.output_row_strobe_n = 1'b0;
		if (next_state == ST_STROBE)
		begin
			case (cur_type)
				MEM_ASYNC:
				begin
					next_strobes.read_column_strobe_n = cur.write;
					next_strobes.output_row_strobe_n  = cur.write;
					next_strobes.write_strobe_n       = ~cur.write;
				end
				MEM_SDRAM:
				begin
					next_strobes.read_column_strobe_n = 1'b0;
					next_strobes.write_strobe_n       = ~cur.write;
				end
				MEM_SYNC:
				begin
					// Address strobe for every access with SEC_RSEL_BIT clear, on reads only with it set; read enable only on reads
					next_strobes.read_column_strobe_n = cur_rsel & cur.write;
					next_strobes.output_row_strobe_n  = cur.write;
					next_strobes.write_strobe_n       = ~cur.write;
					next_strobes.fifo_space_output_strobe_n =
						cur.write | (cur.space != FIFO_SPACE);
				end
				default:
					next_strobes = '1;
			endcase
		end
	end

	always_ff @(posedge clk)
	begin
		if (!reset_n)
			strobes <= '1;
		else
			strobes <= next_strobes;
	end

endmodule : emp_pins

// file: logic/emp_pkg.sv
// Shared constants and types of the external memory port pin block
package emp_pkg;

	localparam int EXT_ADDR_W   = 20;
	localparam int BYTE_ADDR_W  = 23;
	localparam int DW_SHIFT     = 3;
	localparam int SPACES       = 4;
	localparam int REG_ADDR_W   = 8;
	localparam int REG_DATA_W   = 32;

	////////////////////////////////////////////////////////////////////////
	// Register offsets (byte addresses)
	localparam logic [7:0] REG_CTRL    = 8'h00;
	localparam logic [7:0] REG_STATUS  = 8'h04;
	localparam logic [7:0] REG_SPACE0  = 8'h10;
	localparam logic [7:0] REG_SPACE_STEP = 8'h04;

	// Control register fields
	localparam int CTRL_DIV_LSB   = 0;
	localparam int CTRL_GPO_BIT   = 4;
	localparam int CTRL_SREF_BIT  = 5;
	// Space secondary control fields
	localparam int SEC_TYPE_LSB   = 0;
	localparam int SEC_RSEL_BIT   = 2;
	// Status fields
	localparam int STAT_STRAP_LSB = 0;
	localparam int STAT_BUSY_BIT  = 4;
	localparam int STAT_RDY_BIT   = 5;

	////////////////////////////////////////////////////////////////////////
	// Clock strap codes, divider settings, space reset value and FIFO space number
	localparam logic [1:0] STRAP_EXT   = 2'h0;
	localparam logic [1:0] STRAP_CPU4  = 2'h1;
	localparam logic [1:0] STRAP_CPU6  = 2'h2;
	localparam logic [1:0] DIV_BY1     = 2'h0;
	localparam logic [1:0] DIV_BY2     = 2'h1;
	localparam logic [1:0] DIV_BY4     = 2'h2;
	localparam logic [1:0] CPU4_HALF   = 2'h2;
	localparam logic [1:0] CPU6_HALF   = 2'h3;
	localparam logic [2:0] SEC_RESET   = 3'h3;
	localparam logic [1:0] FIFO_SPACE  = 2'h3;

	typedef enum logic [1:0] {MEM_ASYNC, MEM_SDRAM, MEM_SYNC, MEM_NONE} emp_mem_type_t;

	typedef struct packed {
		logic                   start;
		logic                   write;
		logic [1:0]             space;
		logic [BYTE_ADDR_W-1:0] byte_addr;
	} emp_acc_req_t;

	typedef struct packed {
		logic read_column_strobe_n;
		logic output_row_strobe_n;
		logic write_strobe_n;
		logic fifo_space_output_strobe_n;
	} emp_strobes_t;

endpackage : emp_pkg

// file: test/emp_mem_model.sv
// Asynchronous memory stand-in that answers on the ready input
`timescale 1ns/1ps
module emp_mem_model
	import emp_pkg::*;
(
	input  wire logic                  clk,
	input  wire emp_pkg::emp_strobes_t strobes,
	input  wire logic [3:0]            wait_cycles,
	output logic                       async_ready_in
);
	import emp_pkg::*;
	logic [3:0] cnt;
	logic       idle;
	assign idle = strobes.read_column_strobe_n && strobes.write_strobe_n;
	always @(posedge clk)
	begin
		if (idle)
			cnt <= 4'h0;
		else if (cnt != 4'hF)
			cnt <= cnt + 4'h1;
	end
	// Pulled up while idle, held low for wait_cycles once strobed
	assign async_ready_in = idle || (cnt >= wait_cycles);
endmodule : emp_mem_model

// file: test/emp_pins_chk.sv
// Concurrent checks on the port pins of the memory port block
`timescale 1ns/1ps
module emp_pins_chk
	import emp_pkg::*;
(
	input wire logic                          clk,
	input wire logic                          reset_n,
	input wire logic                          port_in_clock_pin,
	input wire logic [1:0]                    port_clock_strap_select,
	input wire emp_pkg::emp_acc_req_t         acc_req,
	input wire logic                          acc_busy,
	input wire logic                          full_rate_out_clock,
	input wire logic [emp_pkg::EXT_ADDR_W-1:0] ext_addr_bus,
	input wire logic [emp_pkg::SPACES-1:0]    space_select_n,
	input wire emp_pkg::emp_strobes_t         strobes
);
	import emp_pkg::*;
	logic [1:0] strap_q;
	logic [1:0] up_cnt;
	always_ff @(posedge clk)
	begin
		if (!reset_n)
			strap_q <= port_clock_strap_select;
	end
	always_ff @(posedge clk)
	begin
		if (!reset_n)
			up_cnt <= 2'h0;
		else if (up_cnt != 2'h3)
			up_cnt <= up_cnt + 2'h1;
	end
	////////////////////////////////////////////////////////////////////////
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);
	sequence s_cpu4_cycle;
		##2 $fell(full_rate_out_clock) ##2 $rose(full_rate_out_clock);
	endsequence
	sequence s_cpu6_cycle;
		##3 $fell(full_rate_out_clock) ##3 $rose(full_rate_out_clock);
	endsequence
	a_full_ext_copy: assert property (
		up_cnt == 2'h3 && strap_q != STRAP_CPU4 && strap_q != STRAP_CPU6
		|-> full_rate_out_clock == $past(port_in_clock_pin, 2)) else $error("full rate clock not pin copy");
	a_full_cpu4: assert property (
		up_cnt == 2'h3 && strap_q == STRAP_CPU4 && $rose(full_rate_out_clock) |-> s_cpu4_cycle)
		else $error("full rate clock not core over four");
	a_full_cpu6: assert property (
		up_cnt == 2'h3 && strap_q == STRAP_CPU6 && $rose(full_rate_out_clock) |-> s_cpu6_cycle)
		else $error("full rate clock not core over six");
	a_start_busy: assert property (acc_req.start && !acc_busy |=> acc_busy)
		else $error("access start not taken");
	a_idle_deselect: assert property (!acc_busy |-> space_select_n == 4'hF)
		else $error("space selected while idle");
	a_idle_quiet: assert property (!acc_busy |-> strobes == 4'hF)
		else $error("strobe low while idle");
	a_one_space: assert property (acc_busy |-> $onehot(~space_select_n))
		else $error("not one space selected");
	a_fifo_three: assert property (
		!strobes.fifo_space_output_strobe_n |-> !space_select_n[3] && !strobes.output_row_strobe_n)
		else $error("fifo strobe outside space three read");
	a_addr_dword: assert property (
		$rose(acc_busy) |-> ext_addr_bus == $past(acc_req.byte_addr[BYTE_ADDR_W-1:DW_SHIFT]))
		else $error("address bus not doubleword address");
endmodule : emp_pins_chk
bind emp_pins emp_pins_chk emp_pins_chk_inst (.clk, .reset_n, .port_in_clock_pin, .port_clock_strap_select,
	.acc_req, .acc_busy, .full_rate_out_clock, .ext_addr_bus, .space_select_n, .strobes);

// file: test/emp_pins_tb_top.sv
// Self-checking bench of the memory port pin block
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin tests_run++; if ((got) !== (exp)) begin n_fail++; \
	$display("Error %s expected %0h seen %0h", nm, exp, got); end end
module emp_pins_tb_top;
	import emp_pkg::*;
	logic clk, reset_n, reg_wr, reg_rd, port_in_clock_pin, acc_busy, acc_done, async_ready_in;
	logic full_rate_out_clock, divided_out_clock, sdram_clock_gate;
	logic [7:0] reg_addr;
	logic [31:0] reg_wdata, reg_rdata;
	logic [1:0] port_clock_strap_select;
	logic [3:0] space_select_n, wait_cycles, lows;
	logic [19:0] ext_addr_bus;
	emp_acc_req_t acc_req;
	emp_strobes_t strobes;
	int n_fail, tests_run, p, rl, i;
	localparam logic [3:0] EXP_LOWS [8] = '{4'hC, 4'h2, 4'hC, 4'hE, 4'hC, 4'hA, 4'hD, 4'h2};
	localparam int PER [4] = '{10, 4, 6, 10};
	emp_pins emp_pins_inst (.clk, .reset_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
		.port_in_clock_pin, .port_clock_strap_select, .acc_req, .acc_busy, .acc_done, .async_ready_in,
		.full_rate_out_clock, .divided_out_clock, .ext_addr_bus, .space_select_n, .strobes, .sdram_clock_gate);
	emp_mem_model emp_mem_model_inst (.clk, .strobes, .wait_cycles, .async_ready_in);
	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	always
	begin
		repeat (5) @(posedge clk);
		port_in_clock_pin <= ~port_in_clock_pin;
	end
	////////////////////////////////////////////////////////////////////////
	task automatic do_reset(input logic [1:0] s);
		@(posedge clk);
		reset_n <= 1'b0;
		port_clock_strap_select <= s;
		repeat (20) @(posedge clk);
		reset_n <= 1'b1;
	endtask : do_reset
	task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask : reg_write
	task automatic reg_read(input logic [7:0] a, input logic [31:0] e);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1;
		`CHK("reg_rdata", e, reg_rdata)
	endtask : reg_read
	task automatic period(input bit sel, output int pr);
		int n, first;
		logic a, b;
		first = -1;
		pr = 0;
		a = 1'b1;
		for (n = 0; n < 400 && pr == 0; n++)
		begin
			@(posedge clk);
			#1;
			b = sel ? divided_out_clock : full_rate_out_clock;
			if (b && !a && first >= 0)
				pr = n - first;
			else if (b && !a)
				first = n;
			a = b;
		end
	endtask : period
	task automatic access(input logic wr, input logic [1:0] sp);
		int n;
		lows = 4'h0;
		rl = 0;
		@(posedge clk);
		acc_req <= '{start: 1'b1, write: wr, space: sp, byte_addr: {sp, 21'h0ABCD8}};
		@(posedge clk);
		acc_req.start <= 1'b0;
		#1;
		for (n = 0; n < 300 && !acc_done; n++)
		begin
			lows |= ~strobes;
			rl += int'(!strobes.read_column_strobe_n);
			@(posedge clk);
			#1;
		end
		`CHK("acc_done", 1'b1, acc_done)
	endtask : access
	task automatic summarize;
		$display("comparisons %0d mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : summarize
	////////////////////////////////////////////////////////////////////////
	initial
	begin
		{reset_n, reg_wr, reg_rd, port_in_clock_pin} = 4'h0;
		{reg_addr, reg_wdata, port_clock_strap_select} = '0;
		acc_req = '0;
		wait_cycles = 4'h2;
		n_fail = 0;
		tests_run = 0;
		do_reset(STRAP_EXT);
		reg_read(REG_CTRL, 32'h10);
		reg_read(REG_STATUS, 32'h20);
		reg_read(8'h40, 32'h0);
		for (i = 0; i < 4; i++)
			reg_read(8'(REG_SPACE0 + 4 * i), 32'(SEC_RESET));
		period(1'b0, p);
		`CHK("full_rate_period", 10, p)
		for (i = 0; i < 4; i++)
		begin
			reg_write(REG_CTRL, 32'h10 | i);
			period(1'b1, p);
			`CHK("divided_period", (i == 3) ? 20 : 10 << i, p)
		end
		reg_write(REG_SPACE0, 32'h0);
		reg_write(8'h14, 32'h1);
		reg_write(8'h18, 32'h2);
		reg_write(8'h1C, 32'h6);
		for (i = 0; i < 8; i++)
		begin
			access(i[0], i[2:1]);
			`CHK("strobes_low", EXP_LOWS[i], lows)
		end
		for (i = 0; i < 13; i += 12)
		begin
			wait_cycles = 4'(i);
			access(1'b0, 2'h0);
			`CHK("read_strobe_held", 1'b1, rl > i)
		end
		reg_write(REG_CTRL, 32'h30);
		repeat (2) @(posedge clk);
		#1;
		`CHK("clock_gate_refresh", 1'b0, sdram_clock_gate)
		reg_write(8'h14, 32'h3);
		access(1'b0, 2'h1);
		`CHK("strobes_none", 4'h0, lows)
		for (i = 0; i < 2; i++)
		begin
			reg_write(REG_CTRL, 32'(i) << CTRL_GPO_BIT);
			repeat (2) @(posedge clk);
			#1;
			`CHK("clock_gate_gpo", i[0], sdram_clock_gate)
		end
		for (i = 1; i < 4; i++)
		begin
			do_reset(i[1:0]);
			period(1'b0, p);
			`CHK("strap_period", PER[i], p)
			reg_read(REG_STATUS, 32'h20 | i);
		end
		summarize();
	end
	initial
	begin
		#500000;
		n_fail++;
		summarize();
	end
endmodule : emp_pins_tb_top
